/* verilog/shpi_defines.svh */
// constants of the servo home preset interlock controller
`ifndef SHPI_DEFINES_SVH
`define SHPI_DEFINES_SVH
// ************************************************************
// register map (byte offsets)
// ************************************************************
`define SHPI_OFS_CTRL    12'h000
`define SHPI_OFS_STATUS  12'h004
`define SHPI_OFS_IRQ_ST  12'h008
`define SHPI_OFS_IRQ_EN  12'h00c
`define SHPI_OFS_IRQ_CLR 12'h010
`define SHPI_OFS_HOME    12'h014
`define SHPI_OFS_POS     12'h018
// ************************************************************
// control fields
// ************************************************************
`define SHPI_CTRL_HOME_MODE 0
`define SHPI_CTRL_START     1
`define SHPI_CTRL_RUN       2
`define SHPI_CTRL_SERVO_ON  3
// ************************************************************
// interrupt fields
// ************************************************************
`define SHPI_IRQ_COORD_ERR  0
`define SHPI_IRQ_HOME_DONE  1
`define SHPI_IRQ_START_REJ  2
// ************************************************************
// reset values and timing
// ************************************************************
`define SHPI_HOME_RESET     32'h0000_01f4
`define SHPI_CLK_HZ         40000000
`define SHPI_CLEAR_MS       100
`define SHPI_CLEAR_CYCLES   ((`SHPI_CLK_HZ / 1000) * `SHPI_CLEAR_MS)
`endif

/* verilog/shpi_pkg.sv */
// types of the servo home preset interlock controller
package shpi_pkg;
  // home sequence states
  typedef enum logic [1:0] {
    SHPI_IDLE  = 2'b00,
    SHPI_CLEAR = 2'b01,
    SHPI_DONE  = 2'b10
  } shpi_state_t;
endpackage : shpi_pkg

/* verilog/shpi_if.sv */
// link between bus slave and sequencing core
`timescale 1ns/1ps
interface shpi_if;
  logic        home_mode;   // home-return mode selected
  logic        start_req;   // start pulse written by software
  logic        run_req;     // axis run request level
  logic        clear_busy;  // clear timer running
  logic        home_done;   // preset home loaded pulse
  modport core (input home_mode, start_req, run_req, output clear_busy, home_done);
  modport host (output home_mode, start_req, run_req, input clear_busy, home_done);
endinterface : shpi_if

/* verilog/shpi_clear_timer.sv */
// position clear pulse timer for one axis
`timescale 1ns/1ps
`include "shpi_defines.svh"
module shpi_clear_timer #(
  parameter int unsigned CYCLES = `SHPI_CLEAR_CYCLES
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic trigger,    // one-cycle start
  output logic      active,     // clear output level
  output logic      expire      // one-cycle end pulse
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic        next_active;
  logic        next_expire;
  // ************************************************************
  // next values
  // ************************************************************
  always_comb begin
    next_count  = count;
    next_active = active;
    next_expire = 1'b0;
    if (trigger && !active) begin
      next_active = 1'b1;
      next_count  = 32'(CYCLES - 1);
    end else if (active) begin
      if (count == 32'h0000_0000) begin
        next_active = 1'b0;
        next_expire = 1'b1;
      end else begin
        next_count = count - 32'h0000_0001;
      end
    end
  end
  // registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count  <= 32'h0000_0000;
      active <= 1'b0;
      expire <= 1'b0;
    end else begin
      count  <= next_count;
      active <= next_active;
      expire <= next_expire;
    end
  end
endmodule : shpi_clear_timer

/* verilog/shpi_top.sv */
// servo home preset interlock controller with ahb-lite registers
//
// The implementer's own choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "shpi_defines.svh"
module shpi_top #(
  parameter int unsigned CLEAR_CYCLES = `SHPI_CLEAR_CYCLES,
  parameter int unsigned POS_W        = 32
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // ahb-lite slave side
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic [31:0]           hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  // servo amplifier and positioning module side
  input  wire logic             abs_send_ready_flag,
  input  wire logic             abs_transfer_mode_output,
  input  wire logic             abs_position_valid,
  input  wire logic [POS_W-1:0] abs_position,
  input  wire logic             home_return_start_button,
  input  wire logic             positioning_input,
  input  wire logic             rev_done,
  // sequencing outputs
  output logic                  position_clear_output,
  output logic                  abs_coordinate_error,
  output logic                  controller_ready_output,
  output logic                  axis_start,
  output logic                  servo_on,
  output logic                  torque_limit_enable,
  output logic                  present_write,
  output logic [31:0]           home_address_register,
  output logic                  irq
);
  // ************************************************************
  // bus slave state
  // ************************************************************
  logic        ap_valid;
  logic        next_ap_valid;
  logic        ap_write;
  logic        next_ap_write;
  logic [11:0] ap_addr;
  logic [11:0] next_ap_addr;
  logic [3:0]  ctrl;
  logic [3:0]  next_ctrl;
  logic [2:0]  irq_st;
  logic [2:0]  next_irq_st;
  logic [2:0]  irq_en;
  logic [2:0]  next_irq_en;
  logic [31:0] next_home;
  logic [31:0] next_hrdata;
  logic        start_pulse;
  logic        next_start_pulse;
  // ************************************************************
  // sequencing state
  // ************************************************************
  shpi_pkg::shpi_state_t state;
  shpi_pkg::shpi_state_t next_state;
  logic        btn_q;          // previous button sample
  logic        next_btn_q;
  logic        preset_home_request;
  logic        next_preset;
  logic        next_err;
  logic        next_present;
  logic        next_start;
  logic        next_ready;
  logic        rejected;
  logic        next_rejected;
  logic        clear_pulse_request;
  logic        clear_busy;
  logic        clear_end;
  logic        bus_we;
  // signals shared by the bus slave and the sequencer
  shpi_if      link ();
  // field helper used by the write decode; readback decodes haddr in a case
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction : hit
  // a write lands at the end of its data phase
  assign bus_we = ap_valid && ap_write;
  // core side of the link
  assign link.home_mode = ctrl[`SHPI_CTRL_HOME_MODE];
  assign link.start_req = start_pulse;
  assign link.run_req   = ctrl[`SHPI_CTRL_RUN];
  assign link.clear_busy = clear_busy;
  assign link.home_done  = clear_end;
  // ************************************************************
  // ahb-lite slave: zero wait states, always okay
  // ************************************************************
  always_comb begin
    next_ap_valid    = hsel && hready && htrans[1];
    next_ap_write    = hwrite;
    next_ap_addr     = haddr[11:0];
    next_ctrl        = ctrl;
    next_irq_en      = irq_en;
    next_home        = home_address_register;
    next_start_pulse = 1'b0;
    next_hrdata      = 32'h0000_0000;
    // control write: the start bit is a strobe and is never stored
    if (bus_we && hit(ap_addr, `SHPI_OFS_CTRL)) begin
      next_ctrl        = {hwdata[3:2], 1'b0, hwdata[0]};
      next_start_pulse = hwdata[`SHPI_CTRL_START];
    end
    if (bus_we && hit(ap_addr, `SHPI_OFS_IRQ_EN)) begin
      next_irq_en = hwdata[2:0];
    end
    // software chooses the home address before the home return
    if (bus_we && hit(ap_addr, `SHPI_OFS_HOME)) begin
      next_home = hwdata;
    end
    // the chosen address stays loaded when the clear pulse ends
    if (preset_home_request && clear_end) begin
      next_home = home_address_register;
    end
    // read data prepared for the next data phase
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[11:0])
        `SHPI_OFS_CTRL:   next_hrdata = {28'h0000000, ctrl};
        `SHPI_OFS_STATUS: next_hrdata = {26'h0000000, rejected, abs_send_ready_flag,
                                         clear_busy, abs_transfer_mode_output,
                                         abs_coordinate_error, position_clear_output};
        `SHPI_OFS_IRQ_ST: next_hrdata = {29'h00000000, irq_st};
        `SHPI_OFS_IRQ_EN: next_hrdata = {29'h00000000, irq_en};
        `SHPI_OFS_HOME:   next_hrdata = home_address_register;
        `SHPI_OFS_POS:    next_hrdata = 32'(abs_position);
        default:          next_hrdata = 32'h0000_0000;
      endcase
    end
  end
  // ************************************************************
  // sticky interrupt status, set beats clear
  // ************************************************************
  always_comb begin
    next_irq_st = irq_st;
    // clear first, so an event in the same cycle wins
    if (bus_we && hit(ap_addr, `SHPI_OFS_IRQ_CLR)) begin
      next_irq_st = irq_st & ~hwdata[2:0];
    end
    // events: new coordinate error, finished clear, refused start
    if (next_err && !abs_coordinate_error) begin
      next_irq_st[`SHPI_IRQ_COORD_ERR] = 1'b1;
    end
    if (clear_end) begin
      next_irq_st[`SHPI_IRQ_HOME_DONE] = 1'b1;
    end
    if (next_rejected) begin
      next_irq_st[`SHPI_IRQ_START_REJ] = 1'b1;
    end
  end
  // ************************************************************
  // home return sequence and interlocks
  // ************************************************************
  always_comb begin
    next_btn_q    = home_return_start_button;
    next_state    = state;
    next_preset   = preset_home_request;
    next_err      = abs_coordinate_error;
    next_present  = 1'b0;
    next_rejected = 1'b0;
    next_ready    = ctrl[`SHPI_CTRL_HOME_MODE];
    // coordinate error on negative absolute data, cleared by new transfer
    if (abs_position_valid && abs_position[POS_W-1]) begin
      next_err = 1'b1;
    end else if (abs_transfer_mode_output) begin
      next_err = 1'b0;
    end
    // start only while absolute data is ready and the axis is quiet
    next_start = link.run_req && abs_send_ready_flag && !abs_transfer_mode_output;
    if (link.run_req && !abs_send_ready_flag) begin
      next_rejected = 1'b1;
    end
    // idle, clear while the timer runs, done for one cycle, idle again;
    // a request is only seen in idle, so a held button or a second
    // strobe during the pulse is ignored
    case (state)
      shpi_pkg::SHPI_IDLE: begin
        if (clear_pulse_request) begin
          next_state  = shpi_pkg::SHPI_CLEAR;
          next_preset = 1'b1;
        end
      end
      shpi_pkg::SHPI_CLEAR: begin
        if (clear_end) begin
          next_state   = shpi_pkg::SHPI_DONE;
          next_preset  = 1'b0;
          next_present = 1'b1;
        end
      end
      shpi_pkg::SHPI_DONE: begin
        next_state = shpi_pkg::SHPI_IDLE;
      end
      default: begin
        next_state = shpi_pkg::SHPI_IDLE;
      end
    endcase
  end
  // the clear line moves the amplifier's position reference, so the
  // request needs every interlock at once; the button edge gives one
  // pulse per press however long the button is held
  // request: home mode, not transferring, positioning idle, revolution done
  assign clear_pulse_request = (state == shpi_pkg::SHPI_IDLE) && link.home_mode
                             && !abs_transfer_mode_output && !positioning_input && rev_done
                             && ((home_return_start_button && !btn_q) || link.start_req);
  // clear pulse timer; its end pulse drops the clear line, which the sequencer raises
  // a second axis gets its own instance, flags and registers
  shpi_clear_timer #(
    .CYCLES  (CLEAR_CYCLES)
  ) u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .trigger (clear_pulse_request),
    .active  (clear_busy),
    .expire  (clear_end)
  );
  // ************************************************************
  // bus slave registers
  // ************************************************************
  // address phase capture, software registers and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_valid                <= 1'b0;
      ap_write                <= 1'b0;
      ap_addr                 <= 12'h000;
      ctrl                    <= 4'h0;
      irq_en                  <= 3'h0;
      home_address_register   <= `SHPI_HOME_RESET;
      hrdata                  <= 32'h0000_0000;
      start_pulse             <= 1'b0;
      hreadyout               <= 1'b1;
      hresp                   <= 1'b0;
    end else begin
      ap_valid                <= next_ap_valid;
      ap_write                <= next_ap_write;
      ap_addr                 <= next_ap_addr;
      ctrl                    <= next_ctrl;
      irq_en                  <= next_irq_en;
      home_address_register   <= next_home;
      hrdata                  <= next_hrdata;
      start_pulse             <= next_start_pulse;
      hreadyout               <= 1'b1;                   // zero wait states
      hresp                   <= 1'b0;                   // always okay
    end
  end
  // ************************************************************
  // interrupt registers
  // ************************************************************
  // the line follows status and enable as they stand after this edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st                  <= 3'h0;
      irq                     <= 1'b0;
    end else begin
      irq_st                  <= next_irq_st;
      irq                     <= |(next_irq_st & next_irq_en);
    end
  end
  // ************************************************************
  // sequence registers
  // ************************************************************
  // home return state, button history and the clear line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state                   <= shpi_pkg::SHPI_IDLE;
      btn_q                   <= 1'b0;
      preset_home_request     <= 1'b0;
      present_write           <= 1'b0;
      position_clear_output   <= 1'b0;
    end else begin
      state                   <= next_state;
      btn_q                   <= next_btn_q;
      preset_home_request     <= next_preset;
      present_write           <= next_present;
      position_clear_output   <= next_preset;
    end
  end
  // ************************************************************
  // interlock registers
  // ************************************************************
  // coordinate error, start gate and the levels seen by the amplifier
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      abs_coordinate_error    <= 1'b0;
      axis_start              <= 1'b0;
      rejected                <= 1'b0;
      controller_ready_output <= 1'b0;
      servo_on                <= 1'b0;
      torque_limit_enable     <= 1'b0;
    end else begin
      abs_coordinate_error    <= next_err;
      axis_start              <= next_start;
      rejected                <= next_rejected;
      controller_ready_output <= next_ready;
      servo_on                <= ctrl[`SHPI_CTRL_SERVO_ON];
      torque_limit_enable     <= 1'b0;
    end
  end
endmodule : shpi_top

/* bench/shpi_monitor.sv */
// assertion checker of the home preset interlock controller
`timescale 1ns/1ps
module shpi_monitor #(
  parameter int unsigned CLEAR_CYCLES = 20,
  parameter int unsigned POS_W        = 32
) (
  input wire logic             hclk,
  input wire logic             hresetn,
  input wire logic             abs_send_ready_flag,
  input wire logic             abs_transfer_mode_output,
  input wire logic             abs_position_valid,
  input wire logic [POS_W-1:0] abs_position,
  input wire logic             positioning_input,
  input wire logic             rev_done,
  input wire logic             position_clear_output,
  input wire logic             abs_coordinate_error,
  input wire logic             controller_ready_output,
  input wire logic             axis_start,
  input wire logic             torque_limit_enable,
  input wire logic             present_write
);
  int unsigned clr_len;  // cycles the clear output has stood high
  // ************************************************************
  // helper counter
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clr_len <= 0;
    end else begin
      clr_len <= position_clear_output ? clr_len + 1 : 0;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ************************************************************
  // properties
  // ************************************************************
  property p_start_ready;
    axis_start |-> $past(abs_send_ready_flag) && !$past(abs_transfer_mode_output);
  endproperty
  a_start_ready: assert property (p_start_ready) else $error("start without ready");
  property p_xfer_stop;
    abs_transfer_mode_output |=> !axis_start;
  endproperty
  a_xfer_stop: assert property (p_xfer_stop) else $error("start during transfer");
  property p_torque_off;
    !torque_limit_enable;
  endproperty
  a_torque_off: assert property (p_torque_off) else $error("torque limit on");
  property p_clear_home;
    $rose(position_clear_output) |-> $past(controller_ready_output) && $past(rev_done)
      && !$past(positioning_input) && !$past(abs_transfer_mode_output);
  endproperty
  a_clear_home: assert property (p_clear_home) else $error("clear outside home");
  property p_clear_len;
    $fell(position_clear_output) |-> clr_len >= CLEAR_CYCLES && clr_len <= CLEAR_CYCLES + 1;
  endproperty
  a_clear_len: assert property (p_clear_len) else $error("clear pulse length");
  property p_preset;
    $fell(position_clear_output) |-> ##[0:1] present_write;
  endproperty
  a_preset: assert property (p_preset) else $error("no present write");
  property p_present_cause;
    present_write |-> $past(position_clear_output) || $past(position_clear_output, 2);
  endproperty
  a_present_cause: assert property (p_present_cause) else $error("stray present write");
  property p_coord_set;
    abs_position_valid && abs_position[POS_W-1] && !abs_transfer_mode_output
      |-> ##[1:2] abs_coordinate_error;
  endproperty
  a_coord_set: assert property (p_coord_set) else $error("coordinate error missed");
  c_clear: cover property ($rose(position_clear_output));
  c_coord: cover property ($rose(abs_coordinate_error));
  c_start: cover property ($rose(axis_start));
endmodule : shpi_monitor
bind shpi_top shpi_monitor #(.CLEAR_CYCLES(CLEAR_CYCLES), .POS_W(POS_W)) u_mon (
  .hclk, .hresetn, .abs_send_ready_flag, .abs_transfer_mode_output, .abs_position_valid,
  .abs_position, .positioning_input, .rev_done, .position_clear_output, .abs_coordinate_error,
  .controller_ready_output, .axis_start, .torque_limit_enable, .present_write);

/* bench/shpi_servo_model.sv */
// behavioural servo amplifier and positioning module for one axis
`timescale 1ns/1ps
module shpi_servo_model #(
  parameter int unsigned XFER_CYCLES = 40,     // length of the absolute transfer
  parameter int unsigned REV_CYCLES  = 30,     // cycles for more than one revolution
  parameter logic [3:0]  BRAKE_CFG   = 4'ha,   // first parameter, pattern 1x1x
  parameter int unsigned POS_W       = 32
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             servo_on,
  input  wire logic             torque_limit_enable,
  input  wire logic [POS_W-1:0] coord,                     // where the axis stands
  output logic                  abs_transfer_mode_output,
  output logic                  abs_send_ready_flag,
  output logic                  abs_position_valid,
  output logic [POS_W-1:0]      abs_position,
  output logic                  rev_done
);
  int unsigned cnt;         // transfer cycles so far
  int unsigned rev;         // cycles turned with the brake released
  logic        son_q;       // servo-on seen last cycle
  logic        brake_open;  // brake released only when the axis may move
  assign brake_open = BRAKE_CFG[3] & BRAKE_CFG[1] & servo_on & ~abs_transfer_mode_output
                      & ~torque_limit_enable;
  // transfer sequence: motor held still while data goes out
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {abs_transfer_mode_output, abs_send_ready_flag, abs_position_valid} <= '0;
      {son_q, rev_done, cnt, rev} <= '0;
      abs_position <= '0;
    end else begin
      son_q <= servo_on;
      abs_position_valid <= 1'b0;
      abs_position <= ~abs_position;  // released data line wanders
      if (rev >= REV_CYCLES) rev_done <= 1'b1;
      else if (brake_open) rev <= rev + 1;
      if (!servo_on) begin
        abs_transfer_mode_output <= 1'b0;
        abs_send_ready_flag <= 1'b0;
      end else if (!son_q) begin
        abs_transfer_mode_output <= 1'b1;
        cnt <= 0;
      end else if (abs_transfer_mode_output) begin
        cnt <= cnt + 1;
        if (cnt == XFER_CYCLES) begin
          abs_transfer_mode_output <= 1'b0;
          abs_position_valid <= 1'b1;
          abs_position <= coord;
          abs_send_ready_flag <= 1'b1;
        end
      end
    end
  end
endmodule : shpi_servo_model

/* bench/shpi_tb_top.sv */
// self-checking bench of the home preset interlock controller
`timescale 1ns/1ps
`include "shpi_defines.svh"
module shpi_tb_top;
  localparam int unsigned CLR = 20;  // shortened clear time
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, home_return_start_button = 0;
  logic positioning_input = 0, hreadyout, hresp, hready, clr_q = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, coord = 32'h64, home_address_register;
  logic [1:0]  htrans = '0;
  logic [2:0]  hsize = '0;
  logic abs_send_ready_flag, abs_transfer_mode_output, abs_position_valid, rev_done;
  logic [31:0] abs_position;
  logic position_clear_output, abs_coordinate_error, controller_ready_output, axis_start;
  logic servo_on, torque_limit_enable, present_write, irq;
  int bad_count = 0, checks = 0, cycles = 0, rises = 0, clr_n = 0, pw_n = 0;
  assign hready = hreadyout;
  shpi_top #(.CLEAR_CYCLES(CLR)) i_shpi_top (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .abs_send_ready_flag,
    .abs_transfer_mode_output, .abs_position_valid, .abs_position, .home_return_start_button,
    .positioning_input, .rev_done, .position_clear_output, .abs_coordinate_error,
    .controller_ready_output, .axis_start, .servo_on, .torque_limit_enable, .present_write,
    .home_address_register, .irq);
  shpi_servo_model i_shpi_servo_model (.hclk, .hresetn, .servo_on, .torque_limit_enable,
    .coord, .abs_transfer_mode_output, .abs_send_ready_flag, .abs_position_valid,
    .abs_position, .rev_done);
  always #12.5 hclk = ~hclk;
  // ************************************************************
  // pulse counters and hang guard
  // ************************************************************
  always @(posedge hclk) begin
    cycles++;
    clr_q <= position_clear_output;
    if (position_clear_output && !clr_q) rises++;
    if (position_clear_output) clr_n++;
    if (present_write) pw_n++;
    if (cycles == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // one single word transfer, address phase then data phase
  task automatic ahb(logic wr, logic [11:0] ofs, logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    {hsel, hwrite, htrans, hsize, haddr} <= {1'b1, wr, 2'h2, 3'h2, 20'h0, ofs};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : ahb
  task automatic wr(logic [11:0] ofs, logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, ofs, d, r);
  endtask : wr
  task automatic rd(string name, logic [11:0] ofs, logic [31:0] exp);
    logic [31:0] r;
    ahb(1'b0, ofs, 32'h0, r);
    chk(name, r, exp);
  endtask : rd
  // servo off then on, then wait for the transfer to finish
  task automatic servo_cycle(logic [31:0] ctrl);
    wr(`SHPI_OFS_CTRL, ctrl & 32'h7);
    wr(`SHPI_OFS_CTRL, ctrl);
    repeat (3) @(posedge hclk);
    chk("start_in_xfer", axis_start, 0);
    while (abs_send_ready_flag !== 1'b1) @(posedge hclk);
    repeat (3) @(posedge hclk);
  endtask : servo_cycle
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_regs();
    rd("home", `SHPI_OFS_HOME, 32'h1f4);
    wr(12'h040, 32'hffffffff);
    rd("unmapped", 12'h040, 32'h0);
    wr(`SHPI_OFS_IRQ_ST, 32'hffffffff);
    rd("irq_st_ro", `SHPI_OFS_IRQ_ST, 32'h0);
    chk("torque", torque_limit_enable, 0);
    chk("hresp", hresp, 0);
  endtask : t_regs
  task automatic t_start();
    wr(`SHPI_OFS_CTRL, 32'h4);
    repeat (3) @(posedge hclk);
    chk("start_not_ready", axis_start, 0);
    rd("start_rej", `SHPI_OFS_IRQ_ST, 32'h4);
    servo_cycle(32'hc);
    chk("start_ready", axis_start, 1);
    rd("status", `SHPI_OFS_STATUS, 32'h10);
    chk("coord_ok", abs_coordinate_error, 0);
  endtask : t_start
  task automatic t_coord();
    coord <= 32'hfffffff0;
    wr(`SHPI_OFS_IRQ_EN, 32'h1);
    servo_cycle(32'hc);
    chk("coord_err", abs_coordinate_error, 1);
    chk("irq_on", irq, 1);
    wr(`SHPI_OFS_IRQ_EN, 32'h0);
    repeat (2) @(posedge hclk);
    chk("irq_masked", irq, 0);
    wr(`SHPI_OFS_IRQ_EN, 32'h1);
    wr(`SHPI_OFS_IRQ_CLR, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq_cleared", irq, 0);
    coord <= 32'h64;
    servo_cycle(32'hc);
    chk("coord_recovered", abs_coordinate_error, 0);
  endtask : t_coord
  task automatic t_home();
    wr(`SHPI_OFS_CTRL, 32'h9);
    wr(`SHPI_OFS_IRQ_CLR, 32'h7);
    positioning_input <= 1'b1;
    repeat (5) @(posedge hclk) home_return_start_button <= 1'b1;
    repeat (40) @(posedge hclk) home_return_start_button <= 1'b0;
    chk("clear_blocked", rises, 0);
    chk("ready_out", controller_ready_output, 1);
    positioning_input <= 1'b0;
    clr_n = 0;
    repeat (60) @(posedge hclk) home_return_start_button <= 1'b1;
    repeat (20) @(posedge hclk) home_return_start_button <= 1'b0;
    chk("one_pulse", rises, 1);
    chk("clear_len", 32'(clr_n == CLR || clr_n == CLR + 1), 1);
    chk("present_write", pw_n, 1);
    chk("home_addr", home_address_register, 32'h1f4);
    rd("home_done", `SHPI_OFS_IRQ_ST, 32'h2);
  endtask : t_home
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_start();
    t_coord();
    t_home();
    report_and_stop();
  end
endmodule : shpi_tb_top
